// file: cln_regs.svh
`ifndef CLN_REGS_SVH
`define CLN_REGS_SVH

// widths
`define CLN_CH_N 4
`define CLN_CFG_W 32
`define CLN_HARM_W 9
`define CLN_ADDR_W 10
`define CLN_LIM_W 16
`define CLN_ENTRY_W 35

// limit entry layout
`define CLN_ENT_LLIM_LSB 0
`define CLN_ENT_PLIM_LSB 16
`define CLN_ENT_PREF_BIT 32
`define CLN_ENT_TYPE_LSB 33
`define CLN_LIM_SIGN 15

// field ranges
`define CLN_HARM_MIN 9'h001
`define CLN_HARM_MAX 9'h1f4
`define CLN_TYPE_NONE 2'h0
`define CLN_TYPE_MAX 2'h2
`define CLN_SEL_MAX 2'h1
`define CLN_OPT_ALL 2'h0
`define CLN_QTY_V 1'b0
`define CLN_QTY_A 1'b1

// sweep bounds
`define CLN_ADDR_FIRST 10'h000
`define CLN_ADDR_LAST 10'h3ff

// response kinds
`define CLN_RSP_ACTIVE 2'h0
`define CLN_RSP_ERROR 2'h1
`define CLN_RSP_LIMIT 2'h2

// reset values and the all-channel mask
`define CLN_FLAGS_RESET 4'h0
`define CLN_CH_ALL 4'hf
`define CLN_CFG_RESET 32'h0000_0000
`define CLN_ENTRY_ZERO 35'h0_0000_0000
`define CLN_LIM_ZERO 16'h0000

`endif

// file: cln_pkg.sv
package cln_pkg;

   typedef enum logic [3:0] {
      CMD_NONE,
      CMD_SNAP_SAVE,
      CMD_SNAP_RESTORE,
      CMD_HLIM_CLEAR,
      CMD_HLIM_SET,
      CMD_HLIM_QUERY,
      CMD_HLIM_COMMIT,
      CMD_NULL_START,
      CMD_NULL_END,
      CMD_NULL_ACTIVE_QUERY,
      CMD_NULL_ERROR_QUERY,
      CMD_EXT_NULL
   } cln_cmd_t;

   typedef enum logic [1:0] {
      ST_INIT,
      ST_IDLE,
      ST_CLEAR,
      ST_QUERY
   } cln_state_t;

endpackage

// file: cln_limit_mem.sv
`timescale 1ns/1ps
`include "cln_regs.svh"

module cln_limit_mem (
   // clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // write port
   input wire logic wr_en_in,
   input wire logic [`CLN_ADDR_W-1:0] wr_addr_in,
   input wire logic [`CLN_ENTRY_W-1:0] wr_data_in,
   // read port a
   input wire logic [`CLN_ADDR_W-1:0] ra_addr_in,
   output logic [`CLN_ENTRY_W-1:0] ra_data_out,
   // read port b
   input wire logic [`CLN_ADDR_W-1:0] rb_addr_in,
   output logic [`CLN_ENTRY_W-1:0] rb_data_out
);

   // volatile limit table, index {quantity, harmonic}
   logic [`CLN_ENTRY_W-1:0] mem [0:(1<<`CLN_ADDR_W)-1];

   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ra_data_out <= `CLN_ENTRY_ZERO;
         rb_data_out <= `CLN_ENTRY_ZERO;
      end else begin
         ra_data_out <= mem[ra_addr_in];
         rb_data_out <= mem[rb_addr_in];
      end
   end

endmodule // cln_limit_mem

// file: cln_top.sv
`timescale 1ns/1ps
`include "cln_regs.svh"

module cln_top (
   // clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic ARST_N_IN,
   // command request
   input wire logic CMD_VALID_IN,
   input wire logic [3:0] CMD_CODE_IN,
   input wire logic CMD_QTY_IN,
   input wire logic [`CLN_HARM_W-1:0] CMD_HARM_IN,
   input wire logic [1:0] CMD_TYPE_IN,
   input wire logic [1:0] CMD_PREF_IN,
   input wire logic [`CLN_LIM_W-1:0] CMD_PLIMIT_IN,
   input wire logic [`CLN_LIM_W-1:0] CMD_LLIMIT_IN,
   input wire logic [1:0] CMD_OPT_IN,
   // command status
   output logic CMD_READY_OUT,
   output logic CMD_DONE_OUT,
   output logic CMD_ERR_OUT,
   // query response
   output logic RSP_VALID_OUT,
   output logic [1:0] RSP_KIND_OUT,
   output logic [`CLN_CH_N-1:0] RSP_FLAGS_OUT,
   output logic RSP_QTY_OUT,
   output logic [`CLN_HARM_W-1:0] RSP_HARM_OUT,
   output logic [1:0] RSP_TYPE_OUT,
   output logic RSP_PREF_OUT,
   output logic [`CLN_LIM_W-1:0] RSP_PLIMIT_OUT,
   output logic [`CLN_LIM_W-1:0] RSP_LLIMIT_OUT,
   // configuration snapshot
   input wire logic [`CLN_CFG_W-1:0] CFG_CURRENT_IN,
   output logic [`CLN_CFG_W-1:0] CFG_RESTORE_OUT,
   output logic CFG_RESTORE_STB_OUT,
   // limit commit to persistent store
   output logic HLIM_COMMIT_STB_OUT,
   output logic HLIM_COMMIT_QTY_OUT,
   // limit lookup for the evaluator
   input wire logic EVAL_QTY_IN,
   input wire logic [`CLN_HARM_W-1:0] EVAL_HARM_IN,
   output logic [1:0] EVAL_TYPE_OUT,
   output logic EVAL_PREF_OUT,
   output logic [`CLN_LIM_W-1:0] EVAL_PLIMIT_OUT,
   output logic [`CLN_LIM_W-1:0] EVAL_LLIMIT_OUT,
   output logic EVAL_ALWAYS_FAIL_OUT,
   // channel offset nulling
   input wire logic [`CLN_CH_N-1:0] CH_CONFIGURED_IN,
   input wire logic [`CLN_CH_N-1:0] CH_SCALED_IN,
   input wire logic [`CLN_CH_N-1:0] CH_NULL_DONE_IN,
   input wire logic [`CLN_CH_N-1:0] CH_NULL_ERR_IN,
   output logic [`CLN_CH_N-1:0] NULL_START_OUT,
   output logic NULL_ABORT_OUT,
   output logic [`CLN_CH_N-1:0] NULL_ACTIVE_OUT,
   output logic [`CLN_CH_N-1:0] NULL_ERROR_OUT,
   output logic MEAS_SUSPEND_OUT,
   output logic [`CLN_CH_N-1:0] EXT_ZERO_OUT
);

   function automatic logic harm_ok(input logic [`CLN_HARM_W-1:0] h);
      harm_ok = (h >= `CLN_HARM_MIN) && (h <= `CLN_HARM_MAX);
   endfunction

   function automatic logic sel_ok(input logic [1:0] s);
      sel_ok = (s <= `CLN_SEL_MAX);
   endfunction

   cln_pkg::cln_state_t state_reg;
   cln_pkg::cln_state_t state_next;
   logic [`CLN_ADDR_W-1:0] cnt_reg;
   logic [`CLN_ADDR_W-1:0] cnt_next;
   logic clr_qty_reg;
   logic q_qty_reg;
   logic [`CLN_HARM_W-1:0] q_harm_reg;
   logic [`CLN_CFG_W-1:0] snap_reg;
   logic snap_valid_reg;
   logic snap_valid_next;
   logic [`CLN_CH_N-1:0] active_next;
   logic [`CLN_CH_N-1:0] error_next;
   logic suspend_next;
   logic [`CLN_ENTRY_W-1:0] ra_data;
   logic [`CLN_ENTRY_W-1:0] rb_data;

   // command decode
   wire idle = (state_reg == cln_pkg::ST_IDLE);
   wire take = CMD_VALID_IN & idle;
   wire is_save = take & (CMD_CODE_IN == cln_pkg::CMD_SNAP_SAVE);
   wire is_restore = take & (CMD_CODE_IN == cln_pkg::CMD_SNAP_RESTORE);
   wire is_clear = take & (CMD_CODE_IN == cln_pkg::CMD_HLIM_CLEAR);
   wire is_set = take & (CMD_CODE_IN == cln_pkg::CMD_HLIM_SET);
   wire is_query = take & (CMD_CODE_IN == cln_pkg::CMD_HLIM_QUERY);
   wire is_commit = take & (CMD_CODE_IN == cln_pkg::CMD_HLIM_COMMIT);
   wire is_start = take & (CMD_CODE_IN == cln_pkg::CMD_NULL_START);
   wire is_end = take & (CMD_CODE_IN == cln_pkg::CMD_NULL_END);
   wire is_qact = take & (CMD_CODE_IN == cln_pkg::CMD_NULL_ACTIVE_QUERY);
   wire is_qerr = take & (CMD_CODE_IN == cln_pkg::CMD_NULL_ERROR_QUERY);
   wire is_ext = take & (CMD_CODE_IN == cln_pkg::CMD_EXT_NULL);
   wire known = is_save | is_restore | is_clear | is_set | is_query |
                is_commit | is_start | is_end | is_qact | is_qerr | is_ext;

   // field checks
   wire type_used = (CMD_TYPE_IN != `CLN_TYPE_NONE);
   wire lim_neg = CMD_PLIMIT_IN[`CLN_LIM_SIGN] |
                  CMD_LLIMIT_IN[`CLN_LIM_SIGN];
   wire set_bad = !harm_ok(CMD_HARM_IN) |
                  (CMD_TYPE_IN > `CLN_TYPE_MAX) |
                  (type_used & (!sel_ok(CMD_PREF_IN) | lim_neg));
   wire set_ok = is_set & !set_bad;
   wire restore_ok = is_restore & snap_valid_reg;
   wire query_ok = is_query & harm_ok(CMD_HARM_IN);
   wire ext_ok = is_ext & sel_ok(CMD_OPT_IN);
   wire cmd_err = take & (!known |
                  (is_restore & !snap_valid_reg) |
                  (is_set & set_bad) |
                  (is_query & !harm_ok(CMD_HARM_IN)) |
                  (is_ext & !sel_ok(CMD_OPT_IN)));
   wire imm_done = take & known & !cmd_err & !is_clear & !is_query;

   // sweep control
   wire in_init = (state_reg == cln_pkg::ST_INIT);
   wire in_clear = (state_reg == cln_pkg::ST_CLEAR);
   wire in_query = (state_reg == cln_pkg::ST_QUERY);
   wire sweeping = in_init | in_clear;
   wire init_last = in_init & (cnt_reg == `CLN_ADDR_LAST);
   wire clear_last = in_clear & (cnt_reg[`CLN_HARM_W-1:0] == `CLN_HARM_MAX);

   // limit table write port
   wire [`CLN_ENTRY_W-1:0] set_entry = type_used ?
      {CMD_TYPE_IN, CMD_PREF_IN[0], CMD_PLIMIT_IN, CMD_LLIMIT_IN} :
      `CLN_ENTRY_ZERO;
   wire mem_wr_en = sweeping | set_ok;
   wire [`CLN_ADDR_W-1:0] mem_wr_addr = in_init ? cnt_reg :
      in_clear ? {clr_qty_reg, cnt_reg[`CLN_HARM_W-1:0]} :
      {CMD_QTY_IN, CMD_HARM_IN};
   wire [`CLN_ENTRY_W-1:0] mem_wr_data = sweeping ? `CLN_ENTRY_ZERO :
      set_entry;
   wire [`CLN_ADDR_W-1:0] mem_ra_addr = {EVAL_QTY_IN, EVAL_HARM_IN};
   wire [`CLN_ADDR_W-1:0] mem_rb_addr = {CMD_QTY_IN, CMD_HARM_IN};

   // read data fields
   wire [1:0] ra_type = ra_data[`CLN_ENT_TYPE_LSB +: 2];
   wire [`CLN_LIM_W-1:0] ra_plim = ra_data[`CLN_ENT_PLIM_LSB +: `CLN_LIM_W];
   wire [`CLN_LIM_W-1:0] ra_llim = ra_data[`CLN_ENT_LLIM_LSB +: `CLN_LIM_W];
   wire ra_fail = (ra_type != `CLN_TYPE_NONE) &
                  (ra_plim == `CLN_LIM_ZERO) &
                  (ra_llim == `CLN_LIM_ZERO);

   // external null channel mask
   wire [`CLN_CH_N-1:0] ext_mask = (CMD_OPT_IN == `CLN_OPT_ALL) ?
      `CLN_CH_ALL : CH_SCALED_IN;
   wire rsp_flag_q = is_qact | is_qerr;

   cln_limit_mem u_mem (
      .clk_in(SYS_CLK_IN),
      .arst_n_in(ARST_N_IN),
      .wr_en_in(mem_wr_en),
      .wr_addr_in(mem_wr_addr),
      .wr_data_in(mem_wr_data),
      .ra_addr_in(mem_ra_addr),
      .ra_data_out(ra_data),
      .rb_addr_in(mem_rb_addr),
      .rb_data_out(rb_data)
   );

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         cln_pkg::ST_INIT: begin
            cnt_next = cnt_reg + 10'h001;
            if (init_last) begin
               state_next = cln_pkg::ST_IDLE;
            end
         end
         cln_pkg::ST_IDLE: begin
            if (is_clear) begin
               state_next = cln_pkg::ST_CLEAR;
               cnt_next = {1'b0, `CLN_HARM_MIN};
            end else if (query_ok) begin
               state_next = cln_pkg::ST_QUERY;
            end
         end
         cln_pkg::ST_CLEAR: begin
            cnt_next = cnt_reg + 10'h001;
            if (clear_last) begin
               state_next = cln_pkg::ST_IDLE;
            end
         end
         cln_pkg::ST_QUERY: begin
            state_next = cln_pkg::ST_IDLE;
         end
         default: begin
            state_next = cln_pkg::ST_IDLE;
         end
      endcase
   end

   // snapshot valid flag; save wins over a restore in the same cycle
   always_comb begin
      snap_valid_next = snap_valid_reg;
      if (restore_ok) begin
         snap_valid_next = 1'b0;
      end
      if (is_save) begin
         snap_valid_next = 1'b1;
      end
   end

   // offset nulling flags; hardware sets win over clears
   always_comb begin
      active_next = (NULL_ACTIVE_OUT & ~CH_NULL_DONE_IN &
                     ~{`CLN_CH_N{is_end}}) |
                    ({`CLN_CH_N{is_start}} & CH_CONFIGURED_IN);
      error_next = (NULL_ERROR_OUT & ~{`CLN_CH_N{is_start | is_end}}) |
                   (CH_NULL_ERR_IN & NULL_ACTIVE_OUT);
      suspend_next = MEAS_SUSPEND_OUT;
      if (is_start) begin
         suspend_next = 1'b1;
      end else if (is_end) begin
         suspend_next = 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         state_reg <= cln_pkg::ST_INIT;
         cnt_reg <= `CLN_ADDR_FIRST;
         clr_qty_reg <= `CLN_QTY_V;
         q_qty_reg <= `CLN_QTY_V;
         q_harm_reg <= `CLN_HARM_MIN;
         CMD_READY_OUT <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         if (is_clear) begin
            clr_qty_reg <= CMD_QTY_IN;
         end
         if (query_ok) begin
            q_qty_reg <= CMD_QTY_IN;
            q_harm_reg <= CMD_HARM_IN;
         end
         CMD_READY_OUT <= (state_next == cln_pkg::ST_IDLE);
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         CMD_DONE_OUT <= 1'b0;
         CMD_ERR_OUT <= 1'b0;
      end else begin
         CMD_DONE_OUT <= imm_done | clear_last | in_query;
         CMD_ERR_OUT <= cmd_err;
      end
   end

   // snapshot store; data cleared only by reset, valid flag cleared by reset or by a successful restore
   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         snap_reg <= `CLN_CFG_RESET;
         snap_valid_reg <= 1'b0;
         CFG_RESTORE_OUT <= `CLN_CFG_RESET;
         CFG_RESTORE_STB_OUT <= 1'b0;
      end else begin
         if (is_save) begin
            snap_reg <= CFG_CURRENT_IN;
         end
         snap_valid_reg <= snap_valid_next;
         if (restore_ok) begin
            CFG_RESTORE_OUT <= snap_reg;
         end
         CFG_RESTORE_STB_OUT <= restore_ok;
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         HLIM_COMMIT_STB_OUT <= 1'b0;
         HLIM_COMMIT_QTY_OUT <= `CLN_QTY_V;
      end else begin
         HLIM_COMMIT_STB_OUT <= is_commit;
         if (is_commit) begin
            HLIM_COMMIT_QTY_OUT <= CMD_QTY_IN;
         end
      end
   end

   // query response
   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         RSP_VALID_OUT <= 1'b0;
         RSP_KIND_OUT <= `CLN_RSP_ACTIVE;
         RSP_FLAGS_OUT <= `CLN_FLAGS_RESET;
      end else begin
         RSP_VALID_OUT <= rsp_flag_q | in_query;
         if (is_qact) begin
            RSP_KIND_OUT <= `CLN_RSP_ACTIVE;
            RSP_FLAGS_OUT <= NULL_ACTIVE_OUT;
         end else if (is_qerr) begin
            RSP_KIND_OUT <= `CLN_RSP_ERROR;
            RSP_FLAGS_OUT <= NULL_ERROR_OUT;
         end else if (in_query) begin
            RSP_KIND_OUT <= `CLN_RSP_LIMIT;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         RSP_QTY_OUT <= `CLN_QTY_V;
         RSP_HARM_OUT <= `CLN_HARM_MIN;
         RSP_TYPE_OUT <= `CLN_TYPE_NONE;
         RSP_PREF_OUT <= 1'b0;
         RSP_PLIMIT_OUT <= `CLN_LIM_ZERO;
         RSP_LLIMIT_OUT <= `CLN_LIM_ZERO;
      end else if (in_query) begin
         RSP_QTY_OUT <= q_qty_reg;
         RSP_HARM_OUT <= q_harm_reg;
         RSP_TYPE_OUT <= rb_data[`CLN_ENT_TYPE_LSB +: 2];
         RSP_PREF_OUT <= rb_data[`CLN_ENT_PREF_BIT];
         RSP_PLIMIT_OUT <= rb_data[`CLN_ENT_PLIM_LSB +: `CLN_LIM_W];
         RSP_LLIMIT_OUT <= rb_data[`CLN_ENT_LLIM_LSB +: `CLN_LIM_W];
      end
   end

   // evaluator lookup, live table contents
   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         EVAL_TYPE_OUT <= `CLN_TYPE_NONE;
         EVAL_PREF_OUT <= 1'b0;
         EVAL_PLIMIT_OUT <= `CLN_LIM_ZERO;
         EVAL_LLIMIT_OUT <= `CLN_LIM_ZERO;
         EVAL_ALWAYS_FAIL_OUT <= 1'b0;
      end else begin
         EVAL_TYPE_OUT <= ra_type;
         EVAL_PREF_OUT <= ra_data[`CLN_ENT_PREF_BIT];
         EVAL_PLIMIT_OUT <= ra_plim;
         EVAL_LLIMIT_OUT <= ra_llim;
         EVAL_ALWAYS_FAIL_OUT <= ra_fail;
      end
   end

   // offset nulling
   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         NULL_ACTIVE_OUT <= `CLN_FLAGS_RESET;
         NULL_ERROR_OUT <= `CLN_FLAGS_RESET;
         MEAS_SUSPEND_OUT <= 1'b0;
      end else begin
         NULL_ACTIVE_OUT <= active_next;
         NULL_ERROR_OUT <= error_next;
         MEAS_SUSPEND_OUT <= suspend_next;
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         NULL_START_OUT <= `CLN_FLAGS_RESET;
         NULL_ABORT_OUT <= 1'b0;
         EXT_ZERO_OUT <= `CLN_FLAGS_RESET;
      end else begin
         NULL_START_OUT <= {`CLN_CH_N{is_start}} & CH_CONFIGURED_IN;
         NULL_ABORT_OUT <= is_end;
         EXT_ZERO_OUT <= {`CLN_CH_N{ext_ok}} & ext_mask;
      end
   end

endmodule // cln_top

// file: cln_checker_properties.sv
`timescale 1ns/1ps
`include "cln_regs.svh"

module cln_checker (
   // clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic ARST_N_IN,
   // command
   input wire logic CMD_VALID_IN,
   input wire logic [3:0] CMD_CODE_IN,
   input wire logic [`CLN_HARM_W-1:0] CMD_HARM_IN,
   input wire logic [1:0] CMD_TYPE_IN,
   input wire logic [1:0] CMD_OPT_IN,
   input wire logic CMD_READY_OUT,
   input wire logic CMD_DONE_OUT,
   input wire logic CMD_ERR_OUT,
   input wire logic RSP_VALID_OUT,
   input wire logic [1:0] RSP_KIND_OUT,
   input wire logic [`CLN_HARM_W-1:0] RSP_HARM_OUT,
   // snapshot and lookup
   input wire logic [`CLN_CFG_W-1:0] CFG_CURRENT_IN,
   input wire logic [`CLN_CFG_W-1:0] CFG_RESTORE_OUT,
   input wire logic CFG_RESTORE_STB_OUT,
   input wire logic [1:0] EVAL_TYPE_OUT,
   input wire logic [`CLN_LIM_W-1:0] EVAL_PLIMIT_OUT,
   input wire logic [`CLN_LIM_W-1:0] EVAL_LLIMIT_OUT,
   input wire logic EVAL_ALWAYS_FAIL_OUT,
   // nulling
   input wire logic [`CLN_CH_N-1:0] CH_CONFIGURED_IN,
   input wire logic [`CLN_CH_N-1:0] CH_SCALED_IN,
   input wire logic [`CLN_CH_N-1:0] CH_NULL_DONE_IN,
   input wire logic [`CLN_CH_N-1:0] CH_NULL_ERR_IN,
   input wire logic [`CLN_CH_N-1:0] NULL_ACTIVE_OUT,
   input wire logic [`CLN_CH_N-1:0] NULL_ERROR_OUT,
   input wire logic MEAS_SUSPEND_OUT,
   input wire logic [`CLN_CH_N-1:0] EXT_ZERO_OUT
);
   wire take = CMD_VALID_IN && CMD_READY_OUT;
   wire save_tk = take && CMD_CODE_IN == cln_pkg::CMD_SNAP_SAVE;
   wire rest_tk = take && CMD_CODE_IN == cln_pkg::CMD_SNAP_RESTORE;
   wire start_tk = take && CMD_CODE_IN == cln_pkg::CMD_NULL_START;
   wire end_tk = take && CMD_CODE_IN == cln_pkg::CMD_NULL_END;
   wire [3:0] hit_err = CH_NULL_ERR_IN & NULL_ACTIVE_OUT;
   logic snap_reg;
   logic [`CLN_CFG_W-1:0] cfg_reg;
   // shadow of the snapshot store
   always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         snap_reg <= 1'b0;
         cfg_reg <= `CLN_CFG_RESET;
      end else if (save_tk) begin
         snap_reg <= 1'b1;
         cfg_reg <= CFG_CURRENT_IN;
      end else if (rest_tk) begin
         snap_reg <= 1'b0;
      end
   end
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!ARST_N_IN);
   a_restore_refused: assert property (
      rest_tk && !snap_reg |=> CMD_ERR_OUT && !CFG_RESTORE_STB_OUT)
      else $error("restore without snapshot taken");
   a_restore_data: assert property (
      rest_tk && snap_reg |=> CFG_RESTORE_STB_OUT && CFG_RESTORE_OUT == cfg_reg)
      else $error("restored snapshot wrong");
   a_set_range: assert property (
      take && CMD_CODE_IN == cln_pkg::CMD_HLIM_SET
      && (CMD_HARM_IN < `CLN_HARM_MIN || CMD_HARM_IN > `CLN_HARM_MAX
      || CMD_TYPE_IN > `CLN_TYPE_MAX) |=> CMD_ERR_OUT && !CMD_DONE_OUT)
      else $error("bad limit set accepted");
   a_query_answer: assert property (
      take && CMD_CODE_IN == cln_pkg::CMD_HLIM_QUERY
      && CMD_HARM_IN >= `CLN_HARM_MIN && CMD_HARM_IN <= `CLN_HARM_MAX
      |=> !CMD_READY_OUT ##1 RSP_VALID_OUT && RSP_KIND_OUT == `CLN_RSP_LIMIT
      && RSP_HARM_OUT == $past(CMD_HARM_IN, 2))
      else $error("limit query answer wrong");
   a_start_flags: assert property (
      start_tk |=> NULL_ACTIVE_OUT == $past(CH_CONFIGURED_IN)
      && NULL_ERROR_OUT == $past(hit_err) && MEAS_SUSPEND_OUT)
      else $error("start flags wrong");
   a_suspend_hold: assert property (
      MEAS_SUSPEND_OUT && !end_tk |=> MEAS_SUSPEND_OUT)
      else $error("suspend dropped before end");
   a_end_clears: assert property (
      end_tk |=> NULL_ACTIVE_OUT == 4'h0 && !MEAS_SUSPEND_OUT
      && NULL_ERROR_OUT == $past(hit_err))
      else $error("end did not clear");
   a_done_clears: assert property (
      CH_NULL_DONE_IN != 4'h0 && !start_tk
      |=> (NULL_ACTIVE_OUT & $past(CH_NULL_DONE_IN)) == 4'h0)
      else $error("active bit kept after done");
   a_err_sets: assert property (
      hit_err != 4'h0 |=> (NULL_ERROR_OUT & $past(hit_err)) == $past(hit_err))
      else $error("error bit not set");
   a_ext_select: assert property (
      take && CMD_CODE_IN == cln_pkg::CMD_EXT_NULL && CMD_OPT_IN <= `CLN_SEL_MAX
      |=> EXT_ZERO_OUT == ($past(CMD_OPT_IN) == `CLN_OPT_ALL ? `CLN_CH_ALL
      : $past(CH_SCALED_IN)))
      else $error("external null mask wrong");
   a_always_fail: assert property (
      EVAL_ALWAYS_FAIL_OUT == (EVAL_TYPE_OUT != `CLN_TYPE_NONE
      && EVAL_PLIMIT_OUT == 16'h0000 && EVAL_LLIMIT_OUT == 16'h0000))
      else $error("always fail flag wrong");
   c_restore: cover property (rest_tk && snap_reg);
   c_null_err: cover property (hit_err != 4'h0);
   c_end: cover property (end_tk);
endmodule // cln_checker

bind cln_top cln_checker chk_u (.*);

// file: cln_chan_model.sv
`timescale 1ns/1ps

module cln_chan_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // from the block
   input wire logic [3:0] start_in,
   input wire logic abort_in,
   // scenario control
   input wire logic [3:0] err_mask_in,
   input wire logic slow_in,
   // to the block
   output logic [3:0] done_out,
   output logic [3:0] err_out
);
   logic [5:0] cnt_reg [4];
   logic fin;
   // per channel nulling run; done or error pulse at the end
   always @(negedge clk_in or negedge arst_n_in) begin
      for (int i = 0; i < 4; i++) begin
         fin = arst_n_in && !abort_in && !start_in[i] && cnt_reg[i] == 6'h01;
         done_out[i] <= fin && !err_mask_in[i];
         err_out[i] <= fin && err_mask_in[i];
         if (!arst_n_in || abort_in) begin
            cnt_reg[i] <= 6'h00;
         end else if (start_in[i]) begin
            cnt_reg[i] <= slow_in ? 6'h30 : 6'(3 + 4 * i);
         end else if (cnt_reg[i] != 6'h00) begin
            cnt_reg[i] <= cnt_reg[i] - 6'h01;
         end
      end
   end
endmodule // cln_chan_model

// file: cln_top_tb.sv
`timescale 1ns/1ps

`define CHK(g, e) begin \
   n_checks++; \
   if ((g) !== (e)) begin \
      error_cnt++; \
      $display("Error at %0t: got %h expected %h", $time, (g), (e)); \
   end \
end

module cln_top_tb;
   logic clk, rst_n, vld, qty, e_qty, slow;
   logic [3:0] code, cfgd, scal, emask;
   logic [8:0] harm, e_harm;
   logic [1:0] typ, pref, opt;
   logic [15:0] pl, ll;
   logic [31:0] cfg;
   wire rdy, done, err, rv, rq, rp, rstb, cstb, cq, ep, ef, abrt, susp;
   wire [1:0] rk, rt, et;
   wire [3:0] rf, nst, act, nerr, ext, cdone, cerr;
   wire [8:0] rh;
   wire [15:0] rpl, rll, epl, ell;
   wire [31:0] rcfg;
   int error_cnt;
   int n_checks;

   cln_top dut_u (.SYS_CLK_IN(clk), .ARST_N_IN(rst_n), .CMD_VALID_IN(vld),
      .CMD_CODE_IN(code), .CMD_QTY_IN(qty), .CMD_HARM_IN(harm),
      .CMD_TYPE_IN(typ), .CMD_PREF_IN(pref), .CMD_PLIMIT_IN(pl),
      .CMD_LLIMIT_IN(ll), .CMD_OPT_IN(opt), .CMD_READY_OUT(rdy),
      .CMD_DONE_OUT(done), .CMD_ERR_OUT(err), .RSP_VALID_OUT(rv),
      .RSP_KIND_OUT(rk), .RSP_FLAGS_OUT(rf), .RSP_QTY_OUT(rq),
      .RSP_HARM_OUT(rh), .RSP_TYPE_OUT(rt), .RSP_PREF_OUT(rp),
      .RSP_PLIMIT_OUT(rpl), .RSP_LLIMIT_OUT(rll), .CFG_CURRENT_IN(cfg),
      .CFG_RESTORE_OUT(rcfg), .CFG_RESTORE_STB_OUT(rstb),
      .HLIM_COMMIT_STB_OUT(cstb), .HLIM_COMMIT_QTY_OUT(cq),
      .EVAL_QTY_IN(e_qty), .EVAL_HARM_IN(e_harm), .EVAL_TYPE_OUT(et),
      .EVAL_PREF_OUT(ep), .EVAL_PLIMIT_OUT(epl), .EVAL_LLIMIT_OUT(ell),
      .EVAL_ALWAYS_FAIL_OUT(ef), .CH_CONFIGURED_IN(cfgd),
      .CH_SCALED_IN(scal), .CH_NULL_DONE_IN(cdone), .CH_NULL_ERR_IN(cerr),
      .NULL_START_OUT(nst), .NULL_ABORT_OUT(abrt), .NULL_ACTIVE_OUT(act),
      .NULL_ERROR_OUT(nerr), .MEAS_SUSPEND_OUT(susp), .EXT_ZERO_OUT(ext));

   cln_chan_model chm_u (.clk_in(clk), .arst_n_in(rst_n), .start_in(nst),
      .abort_in(abrt), .err_mask_in(emask), .slow_in(slow),
      .done_out(cdone), .err_out(cerr));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic give_verdict();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // one command; returns where the one-cycle answer stands
   task automatic send(input logic [3:0] c);
      int k;
      k = 0;
      @(negedge clk);
      while (rdy !== 1'b1 && k < 2000) begin
         @(negedge clk);
         k++;
      end
      if (k >= 2000) begin
         error_cnt++;
      end
      code = c;
      vld = 1'b1;
      @(negedge clk);
      vld = 1'b0;
   endtask

   task automatic lim(input logic [3:0] c, input logic q, input logic [8:0] h,
      input logic [1:0] t, input logic [1:0] p, input logic [15:0] a);
      qty = q;
      harm = h;
      typ = t;
      pref = p;
      pl = a;
      ll = 16'h0034;
      send(c);
   endtask

   task automatic look(input logic q, input logic [8:0] h,
      input logic [1:0] t, input logic f);
      e_qty = q;
      e_harm = h;
      tick(3);
      `CHK({et, ef}, {t, f})
   endtask

   task automatic do_reset();
      rst_n = 1'b0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      `CHK({rdy, act, nerr}, 9'h000)
   endtask

   task automatic t_snap();
      send(4'h2);
      `CHK(err, 1'b1)
      cfg = 32'h1234_abcd;
      send(4'h1);
      `CHK(done, 1'b1)
      cfg = 32'h0000_0000;
      send(4'h2);
      `CHK({rstb, rcfg}, {1'b1, 32'h1234_abcd})
      send(4'h2);
      `CHK(err, 1'b1)
      send(4'h1);
   endtask

   task automatic t_lim();
      logic [28:0] bad [5];
      bad = '{{9'h000, 2'h1, 2'h0, 16'h0001}, {9'h1f5, 2'h1, 2'h0, 16'h0001},
         {9'h1f4, 2'h3, 2'h0, 16'h0001}, {9'h1f4, 2'h1, 2'h2, 16'h0001},
         {9'h1f4, 2'h1, 2'h0, 16'h8000}};
      lim(4'h4, 1'b0, 9'h1f4, 2'h2, 2'h1, 16'h0012);
      `CHK(done, 1'b1)
      look(1'b0, 9'h1f4, 2'h2, 1'b0);
      `CHK({ep, epl, ell}, {1'b1, 16'h0012, 16'h0034})
      for (int i = 0; i < 5; i++) begin
         lim(4'h4, 1'b0, bad[i][28:20], bad[i][19:18], bad[i][17:16],
            bad[i][15:0]);
         `CHK({err, done}, 2'b10)
      end
      send(4'hc);
      `CHK(err, 1'b1)
      send(4'h0);
      `CHK(err, 1'b1)
      lim(4'h5, 1'b0, 9'h1f4, 2'h0, 2'h0, 16'h0000);
      tick(1);
      `CHK({rv, rk, rh, rt, rp}, {1'b1, 2'h2, 9'h1f4, 2'h2, 1'b1})
      `CHK({rpl, rll}, {16'h0012, 16'h0034})
      lim(4'h4, 1'b1, 9'h001, 2'h1, 2'h0, 16'h0000);
      ll = 16'h0000;
      lim(4'h4, 1'b1, 9'h001, 2'h1, 2'h0, 16'h0000);
      look(1'b1, 9'h001, 2'h1, 1'b0);
      ll = 16'h0000;
      qty = 1'b1;
      pl = 16'h0000;
      send(4'h4);
      look(1'b1, 9'h001, 2'h1, 1'b1);
      lim(4'h5, 1'b1, 9'h001, 2'h0, 2'h0, 16'h0000);
      tick(1);
      `CHK({rv, rq, rp}, 3'b110)
      lim(4'h4, 1'b0, 9'h1f4, 2'h0, 2'h1, 16'h0005);
      look(1'b0, 9'h1f4, 2'h0, 1'b0);
      lim(4'h3, 1'b1, 9'h001, 2'h0, 2'h0, 16'h0000);
      `CHK({rdy, done}, 2'b00)
      tick(500);
      `CHK({rdy, done}, 2'b11)
      tick(2);
      look(1'b1, 9'h001, 2'h0, 1'b0);
      lim(4'h6, 1'b1, 9'h001, 2'h0, 2'h0, 16'h0000);
      `CHK({cstb, cq, done}, 3'b111)
   endtask

   task automatic t_null();
      cfgd = 4'hb;
      emask = 4'h2;
      send(4'h7);
      `CHK({nst, act, nerr, susp}, {4'hb, 4'hb, 4'h0, 1'b1})
      tick(20);
      `CHK({act, nerr, susp}, {4'h2, 4'h2, 1'b1})
      send(4'h9);
      `CHK({rv, rk, rf}, {1'b1, 2'h0, 4'h2})
      send(4'ha);
      `CHK({rv, rk, rf}, {1'b1, 2'h1, 4'h2})
      slow = 1'b1;
      send(4'h7);
      `CHK({act, nerr}, 8'hb0)
      tick(5);
      send(4'h8);
      `CHK({abrt, act, nerr, susp}, {1'b1, 4'h0, 4'h0, 1'b0})
   endtask

   task automatic t_ext();
      logic [4:0] exp_v [3];
      exp_v = '{5'h0f, 5'h05, 5'h10};
      scal = 4'h5;
      for (int i = 0; i < 3; i++) begin
         opt = 2'(i);
         send(4'hb);
         `CHK({err, ext}, exp_v[i])
      end
   endtask

   initial begin
      {vld, qty, e_qty, slow, code, cfgd, scal, emask} = 20'h00000;
      {harm, e_harm, typ, pref, opt, pl, ll, cfg} = 88'h0;
      do_reset();
      t_snap();
      t_lim();
      t_null();
      t_ext();
      do_reset();
      send(4'h2);
      `CHK(err, 1'b1)
      give_verdict();
   end

   initial begin
      #(20000 * 50);
      error_cnt++;
      give_verdict();
   end
endmodule // cln_top_tb
